// *** ppil_defines.vh ***
// Register map, field positions and reset values of the port interrupt logic
// Functional notes
// - Port enable bit gates all event interrupts; the test bit bypasses it
// - Test bit forces interrupt output active
// - Autoneg done flag, cleared on status read
// - Speed change flag latched until read
// - Duplex change flag latched until read
// - Link change flag latched until read
// - Pending bit mirrors interrupt output
// - Status read clears flags; writes ignored
// - Per-event masks gate interrupt causes
`ifndef PPIL_DEFINES_VH
`define PPIL_DEFINES_VH
`define PPIL_ADDR_W        5
`define PPIL_DATA_W        16
`define PPIL_REG_ENABLE    5'h12
`define PPIL_REG_STATUS    5'h13
`define PPIL_BIT_AN_MASK   7
`define PPIL_BIT_SPD_MASK  6
`define PPIL_BIT_DPX_MASK  5
`define PPIL_BIT_LNK_MASK  4
`define PPIL_BIT_ALLOW     1
`define PPIL_BIT_FORCE     0
`define PPIL_BIT_AN_DONE   7
`define PPIL_BIT_SPD_CHG   6
`define PPIL_BIT_DPX_CHG   5
`define PPIL_BIT_LNK_CHG   4
`define PPIL_BIT_PENDING   2
`define PPIL_EVT_N         4
`define PPIL_READ_ZERO     16'h0000
`define PPIL_ALLOW_RESET   1'b0
`define PPIL_FORCE_RESET   1'b0
`define PPIL_MASK_RESET    1'b0
`define PPIL_FLAG_RESET    1'b0
`define PPIL_PEND_RESET    1'b0
`define PPIL_IRQ_N_IDLE    1'b1
`endif

// *** ppil_port_irq.v ***
// Per-port interrupt enable and status registers with interrupt output
`timescale 1ns/1ps
`include "ppil_defines.vh"
module ppil_port_irq (
  input  wire                     clk,
  input  wire                     reset_n,
  input  wire [`PPIL_ADDR_W-1:0]  reg_addr,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  input  wire [`PPIL_DATA_W-1:0]  reg_wdata,
  input  wire                     autoneg_done_evt,
  input  wire                     speed_change_evt,
  input  wire                     duplex_change_evt,
  input  wire                     link_change_evt,
  output reg  [`PPIL_DATA_W-1:0]  reg_rdata,
  output reg                      mgmt_irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Enable register fields; reserved bits are not stored
  reg                     port_irq_allow;
  reg                     irq_force_test;
  reg                     autoneg_event_mask;
  reg                     speed_event_mask;
  reg                     duplex_event_mask;
  reg                     link_event_mask;

  // Latched status flags and pending mirror
  reg                     autoneg_done_flag;
  reg                     speed_change_flag;
  reg                     duplex_change_flag;
  reg                     link_change_flag;
  reg                     mgmt_irq_pending;

  reg                     next_autoneg_done_flag;
  reg                     next_speed_change_flag;
  reg                     next_duplex_change_flag;
  reg                     next_link_change_flag;
  reg                     next_irq;
  reg [`PPIL_DATA_W-1:0]  next_reg_rdata;

  ////////////////////////////////////////////////////////////////////////////
  function ppil_addr_is;
    input [`PPIL_ADDR_W-1:0] addr;
    input [`PPIL_ADDR_W-1:0] target;
    begin
      ppil_addr_is = (addr == target);
    end
  endfunction

  // Set wins over clear so an event in the read cycle is kept
  function ppil_flag_next;
    input evt;
    input flag;
    input clear;
    begin
      ppil_flag_next = evt | (flag & ~clear);
    end
  endfunction

  function ppil_irq_level;
    input                   allow;
    input                   force_on;
    input [`PPIL_EVT_N-1:0] masks;
    input [`PPIL_EVT_N-1:0] flags;
    begin
      ppil_irq_level = (allow & (|(masks & flags))) | force_on;
    end
  endfunction

  // Reserved bits always read as zero
  function [`PPIL_DATA_W-1:0] ppil_enable_word;
    input allow;
    input force_on;
    input an_mask;
    input spd_mask;
    input dpx_mask;
    input lnk_mask;
    begin
      ppil_enable_word                     = `PPIL_READ_ZERO;
      ppil_enable_word[`PPIL_BIT_AN_MASK]  = an_mask;
      ppil_enable_word[`PPIL_BIT_SPD_MASK] = spd_mask;
      ppil_enable_word[`PPIL_BIT_DPX_MASK] = dpx_mask;
      ppil_enable_word[`PPIL_BIT_LNK_MASK] = lnk_mask;
      ppil_enable_word[`PPIL_BIT_ALLOW]    = allow;
      ppil_enable_word[`PPIL_BIT_FORCE]    = force_on;
    end
  endfunction

  function [`PPIL_DATA_W-1:0] ppil_status_word;
    input an;
    input spd;
    input dpx;
    input lnk;
    input pend;
    begin
      ppil_status_word                    = `PPIL_READ_ZERO;
      ppil_status_word[`PPIL_BIT_AN_DONE] = an;
      ppil_status_word[`PPIL_BIT_SPD_CHG] = spd;
      ppil_status_word[`PPIL_BIT_DPX_CHG] = dpx;
      ppil_status_word[`PPIL_BIT_LNK_CHG] = lnk;
      ppil_status_word[`PPIL_BIT_PENDING] = pend;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status flags have no write path at all
  wire enable_write = reg_wr & ppil_addr_is(reg_addr, `PPIL_REG_ENABLE);
  wire status_read  = reg_rd &
                      ppil_addr_is(reg_addr, `PPIL_REG_STATUS);

  always @* begin
    next_autoneg_done_flag  = ppil_flag_next(autoneg_done_evt,
                                             autoneg_done_flag,
                                             status_read);
    next_speed_change_flag  = ppil_flag_next(speed_change_evt,
                                             speed_change_flag,
                                             status_read);
    next_duplex_change_flag = ppil_flag_next(duplex_change_evt,
                                             duplex_change_flag,
                                             status_read);
    next_link_change_flag   = ppil_flag_next(link_change_evt,
                                             link_change_flag,
                                             status_read);
  end

  // The cause looks at the next flags so the output tracks them
  always @* begin
    next_irq = ppil_irq_level(port_irq_allow,
                              irq_force_test,
                              {autoneg_event_mask, speed_event_mask,
                               duplex_event_mask, link_event_mask},
                              {next_autoneg_done_flag,
                               next_speed_change_flag,
                               next_duplex_change_flag,
                               next_link_change_flag});
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_irq_allow <= `PPIL_ALLOW_RESET;
    end else if (enable_write) begin
      port_irq_allow <= reg_wdata[`PPIL_BIT_ALLOW];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_force_test <= `PPIL_FORCE_RESET;
    end else if (enable_write) begin
      irq_force_test <= reg_wdata[`PPIL_BIT_FORCE];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      autoneg_event_mask <= `PPIL_MASK_RESET;
    end else if (enable_write) begin
      autoneg_event_mask <= reg_wdata[`PPIL_BIT_AN_MASK];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_event_mask <= `PPIL_MASK_RESET;
    end else if (enable_write) begin
      speed_event_mask <= reg_wdata[`PPIL_BIT_SPD_MASK];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duplex_event_mask <= `PPIL_MASK_RESET;
    end else if (enable_write) begin
      duplex_event_mask <= reg_wdata[`PPIL_BIT_DPX_MASK];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_event_mask <= `PPIL_MASK_RESET;
    end else if (enable_write) begin
      link_event_mask <= reg_wdata[`PPIL_BIT_LNK_MASK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      autoneg_done_flag <= `PPIL_FLAG_RESET;
    end else begin
      autoneg_done_flag <= next_autoneg_done_flag;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_change_flag <= `PPIL_FLAG_RESET;
    end else begin
      speed_change_flag <= next_speed_change_flag;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duplex_change_flag <= `PPIL_FLAG_RESET;
    end else begin
      duplex_change_flag <= next_duplex_change_flag;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_change_flag <= `PPIL_FLAG_RESET;
    end else begin
      link_change_flag <= next_link_change_flag;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_irq_pending <= `PPIL_PEND_RESET;
    end else begin
      mgmt_irq_pending <= next_irq;
    end
  end

  // Same source as the pending bit, so the two never disagree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_irq_n <= `PPIL_IRQ_N_IDLE;
    end else begin
      mgmt_irq_n <= ~next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unmapped addresses return zero
  always @* begin
    case (reg_addr)
      `PPIL_REG_ENABLE: begin
        next_reg_rdata = ppil_enable_word(port_irq_allow, irq_force_test,
                                          autoneg_event_mask,
                                          speed_event_mask,
                                          duplex_event_mask,
                                          link_event_mask);
      end
      `PPIL_REG_STATUS: begin
        next_reg_rdata = ppil_status_word(autoneg_done_flag,
                                          speed_change_flag,
                                          duplex_change_flag,
                                          link_change_flag,
                                          mgmt_irq_pending);
      end
      default: begin
        next_reg_rdata = `PPIL_READ_ZERO;
      end
    endcase
  end

  // Read data holds between reads so a slow host can pick it up
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `PPIL_READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// *** ppil_props.sv ***
// Port assertions of the port interrupt logic
`timescale 1ns/1ps
module ppil_props (
  input wire        clk, reset_n, reg_wr, reg_rd, mgmt_irq_n,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata, reg_rdata
);
  wire [15:0] w = reg_wdata;
  wire [15:0] d = reg_rdata;
  wire        q = mgmt_irq_n;
  wire        we = reg_wr && reg_addr == 5'h12;
  wire        re = reg_rd && reg_addr == 5'h12;
  wire        rs = reg_rd && reg_addr == 5'h13;
  wire        un = reg_rd && reg_addr[4:1] != 4'h9;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_force_irq: assert property (we && w[0] |=> ##1 !q)
    else $error("bad");
  a_allow_off: assert property (we && !w[1:0] |=> ##1 q)
    else $error("bad");
  a_pend_mirror: assert property (rs |=> d[2] == !$past(q))
    else $error("bad");
  a_stat_rsvd: assert property (rs |=> !(d&16'hff0b)) else $error("bad");
  a_en_rsvd: assert property (re |=> !(d&16'hff0c)) else $error("bad");
  a_no_reg: assert property (un |=> !d) else $error("bad");
  a_rd_hold: assert property (!reg_rd |=> $stable(d)) else $error("bad");
  a_en_back: assert property (we ##1 !reg_wr ##1 re
    |=> d == ($past(w, 3) & 16'h00f3)) else $error("bad");
  a_force_hold: assert property (we && w[0] ##1 !reg_wr ##1 rs
    |=> !q) else $error("bad");
endmodule

// *** ppil_host.sv ***
// Management host model driving register reads and writes
`timescale 1ns/1ps
module ppil_host (
  input  wire        clk,
  input  wire [15:0] reg_rdata,
  output reg  [4:0]  reg_addr = 5'h00,
  output reg         reg_wr = 1'b0, reg_rd = 1'b0,
  output reg  [15:0] reg_wdata = 16'h0000
);
  reg [15:0] q;
  task wr(input [4:0] a, input [15:0] v);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk) {reg_wdata, reg_wr} <= {~v, 1'b0};
  endtask
  task rd(input [4:0] a);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
endmodule

// *** test_ppil_port_irq.sv ***
// Self-checking bench for the port interrupt logic
`timescale 1ns/1ps
module test_ppil_port_irq;
  reg         clk = 1'b0, reset_n = 1'b0;
  reg  [3:0]  ev = 4'h0;
  wire [15:0] reg_rdata, reg_wdata;
  wire [4:0]  reg_addr;
  wire        reg_wr, reg_rd, mgmt_irq_n;
  integer     n_fail = 0, checks = 0, i;
  initial forever #25 clk = ~clk;
  ppil_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  ppil_port_irq uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .autoneg_done_evt(ev[3]), .speed_change_evt(ev[2]),
    .duplex_change_evt(ev[1]), .link_change_evt(ev[0]),
    .reg_rdata(reg_rdata), .mgmt_irq_n(mgmt_irq_n));
  task chk(input [15:0] s, e);
    checks = checks + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task rc(input [4:0] a, input [15:0] e);
    host.rd(a);
    chk(host.q, e);
  endtask
  // Level check waits two edges so a registered output has landed
  task ep(input [3:0] v, input [15:0] e);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 4'h0;
    @(posedge clk) #1 chk(mgmt_irq_n, e);
  endtask
  task summarize;
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000 n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rc(5'h12, 16'h0000);
    host.wr(5'h12, 16'h00f2);
    for (i = 0; i < 4; i = i + 1) begin
      ep(4'h1 << i, 16'h0000);
      rc(5'h13, 16'h0010 << i | 16'h0004);
      chk(mgmt_irq_n, 16'h0001);
      rc(5'h13, 16'h0000);
    end
    host.wr(5'h12, 16'h0002);
    ep(4'h1, 16'h0001);
    host.wr(5'h12, 16'h00f1);
    rc(5'h13, 16'h0014);
    chk(mgmt_irq_n, 16'h0000);
    host.wr(5'h13, 16'hffff);
    host.wr(5'h12, 16'h00f3);
    rc(5'h12, 16'h00f3);
    rc(5'h13, 16'h0004);
    host.wr(5'h12, 16'h0000);
    rc(5'h05, 16'h0000);
    chk(mgmt_irq_n, 16'h0001);
    host.wr(5'h12, 16'h00f3);
    rc(5'h12, 16'h00f3);
    ep(4'h1, 16'h0000);
    @(posedge clk) reset_n <= 1'b0;
    @(posedge clk) reset_n <= 1'b1;
    #1 chk(reg_rdata, 16'h0000);
    chk(mgmt_irq_n, 16'h0001);
    rc(5'h12, 16'h0000);
    rc(5'h13, 16'h0000);
    fork
      rc(5'h13, 16'h0000);
      ep(4'h1, 16'h0001);
    join
    rc(5'h13, 16'h0010);
    summarize;
  end
endmodule
bind ppil_port_irq ppil_props chk_i (.clk(clk), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .mgmt_irq_n(mgmt_irq_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
